// *** lsd_companion.sv ***
// companion engine control model: torque, fuel demand and clutch state it reports
// assumes the bench sets the wanted values; they reach the pins one clock later
`timescale 1ns/100ps
`default_nettype none
module lsd_companion
	import lsd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [LSD_PCT_W-1:0] torque_set,
	input wire logic [LSD_PCT_W-1:0] fuel_set,
	input wire logic clutch_set,
	output logic [LSD_PCT_W-1:0] comp_torque,
	output logic [LSD_PCT_W-1:0] comp_fuel,
	output logic comp_clutch_pin
);
	// values lag a cycle like a network update, so the block never sees them early
	always_ff @(posedge sys_clk)
	begin
		comp_torque <= torque_set;
		comp_fuel <= fuel_set;
		comp_clutch_pin <= clutch_set;
	end
endmodule
`default_nettype wire

// *** lsd_pkg.sv ***
// constants and types for the load share deviation supervisor
// assumes a 200 MHz sys_clk and percent values in tenths of a percent
`default_nettype none
package lsd_pkg;
	localparam int LSD_DW = 16;
	localparam int LSD_AW = 8;
	localparam int LSD_PCT_W = 11;
	localparam int LSD_TIME_W = 12;
	localparam int LSD_PRE_W = 24;
	localparam int LSD_CTRL_W = 6;
	// timebase: one tick per hundredth of a second
	localparam int LSD_CLK_PERIOD_NS = 5;
	localparam int LSD_TICK_NS = 10000000;
	localparam int LSD_TICK_CYC = LSD_TICK_NS / LSD_CLK_PERIOD_NS;
	// limits in 0.1 %, times in 0.01 s
	localparam logic [15:0] LSD_LIM_MIN = 16'h0001;
	localparam logic [15:0] LSD_LIM_MAX = 16'h01F4;
	localparam logic [15:0] LSD_TIME_MIN = 16'h0001;
	localparam logic [15:0] LSD_TIME_MAX = 16'h0BB8;
	localparam logic [15:0] LSD_PCT_MAX = 16'h03E8;
	localparam logic [15:0] LSD_LIM_RST = 16'h0064;
	localparam logic [15:0] LSD_TIME_RST = 16'h0064;
	localparam logic [15:0] LSD_TRIP_RST = 16'h0000;
	localparam logic [5:0] LSD_CTRL_RST = 6'h00;
	// register byte addresses
	localparam logic [7:0] LSD_A_CTRL = 8'h00;
	localparam logic [7:0] LSD_A_TQ_LIM = 8'h04;
	localparam logic [7:0] LSD_A_TQ_DWELL = 8'h08;
	localparam logic [7:0] LSD_A_SETTLE = 8'h0C;
	localparam logic [7:0] LSD_A_FUEL_LIM = 8'h10;
	localparam logic [7:0] LSD_A_FUEL_DWELL = 8'h14;
	localparam logic [7:0] LSD_A_TRIP = 8'h18;
	localparam logic [7:0] LSD_A_STATUS = 8'h1C;
	localparam logic [7:0] LSD_A_TQ_DIFF = 8'h20;
	localparam logic [7:0] LSD_A_FUEL_DIFF = 8'h24;
	// control register bit positions
	localparam int LSD_C_MINOR_TQ = 0;
	localparam int LSD_C_MAJOR_TQ = 1;
	localparam int LSD_C_MINOR_FUEL = 2;
	localparam int LSD_C_MINOR_INV = 3;
	localparam int LSD_C_MAJOR_INV = 4;
	localparam int LSD_C_SLAVE = 5;
	// discrete contacts, high while the contact is closed
	typedef struct packed {
		logic pclink_selected;
		logic alarm_reset;
		logic mechanical_governor_selected;
		logic clutch_request;
		logic clutch_engaged;
		logic maneuvering;
		logic declutch_request;
		logic run_stop;
	} lsd_contacts_type;
	// status word, low byte
	typedef struct packed {
		logic [1:0] spare;
		logic settled;
		logic clutch_cmd;
		logic slave_declutch;
		logic major_alarm;
		logic minor_alarm;
		logic fuel_share;
	} lsd_status_type;
endpackage
`default_nettype wire

// *** lsd_supervisor.sv ***
// load share deviation supervisor: mismatch timers, alarms, relays, contacts
// assumes engine values arrive on sys_clk from the scaling logic, contacts from pins
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module lsd_supervisor
	import lsd_pkg::*;
#(
	parameter int TICK_CYCLES = LSD_TICK_CYC
)
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [LSD_AW-1:0] bus_addr,
	input wire logic [LSD_DW-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [LSD_DW-1:0] bus_rdata,
	input wire lsd_contacts_type contact_pins,
	input wire logic comp_clutch_pin,
	input wire logic [LSD_PCT_W-1:0] own_torque,
	input wire logic [LSD_PCT_W-1:0] comp_torque,
	input wire logic [LSD_PCT_W-1:0] own_fuel,
	input wire logic [LSD_PCT_W-1:0] comp_fuel,
	input wire logic [LSD_PCT_W-1:0] engine_load,
	input wire logic clutch_permissive_ok,
	output lsd_contacts_type contact_flags,
	output logic programmer_enable,
	output logic fuel_share,
	output logic minor_alarm,
	output logic major_alarm,
	output logic relay_minor,
	output logic relay_major,
	output logic slave_declutch,
	output logic clutch_cmd,
	output logic [LSD_PCT_W-1:0] torque_difference_readout,
	output logic [LSD_PCT_W-1:0] fuel_difference_readout
);
	function automatic logic [LSD_DW-1:0] clamp(input logic [LSD_DW-1:0] v,
		input logic [LSD_DW-1:0] lo, input logic [LSD_DW-1:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [LSD_PCT_W-1:0] absdiff(input logic [LSD_PCT_W-1:0] a,
		input logic [LSD_PCT_W-1:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	logic [8:0] meta_q, sync_q;
	logic [LSD_CTRL_W-1:0] ctrl_q;
	logic [LSD_DW-1:0] tq_lim_q, tq_dwell_q, settle_q, fuel_lim_q, fuel_dwell_q, trip_q;
	logic [LSD_PRE_W-1:0] pre_q;
	logic [LSD_TIME_W-1:0] settle_cnt_q, tq_cnt_q, fuel_cnt_q;
	logic fuel_share_q, minor_q, major_q, declutch_q, clutch_q, relay1_q, relay2_q, prog_q;
	logic [LSD_PCT_W-1:0] tq_diff_q, fuel_diff_q;
	logic [LSD_DW-1:0] rdata_q, rd_d;
	lsd_contacts_type ct;
	lsd_status_type st;

	// contact and companion clutch pins through two flops; only sync_q is read
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else if (ce)
		begin
			meta_q <= {comp_clutch_pin, contact_pins};
			sync_q <= meta_q;
		end
	end
	assign ct = lsd_contacts_type'(sync_q[7:0]);

	// register decode
	wire wr_en = bus_wr & ce;
	wire wr_ctrl = wr_en && bus_addr == LSD_A_CTRL;
	wire wr_tq_lim = wr_en && bus_addr == LSD_A_TQ_LIM;
	wire wr_tq_dwell = wr_en && bus_addr == LSD_A_TQ_DWELL;
	wire wr_settle = wr_en && bus_addr == LSD_A_SETTLE;
	wire wr_fuel_lim = wr_en && bus_addr == LSD_A_FUEL_LIM;
	wire wr_fuel_dwell = wr_en && bus_addr == LSD_A_FUEL_DWELL;
	wire wr_trip = wr_en && bus_addr == LSD_A_TRIP;

	// settings clamp on write so the timers never see an out-of-range value
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			ctrl_q <= LSD_CTRL_RST;
			tq_lim_q <= LSD_LIM_RST;
			tq_dwell_q <= LSD_TIME_RST;
			settle_q <= LSD_TIME_RST;
			fuel_lim_q <= LSD_LIM_RST;
			fuel_dwell_q <= LSD_TIME_RST;
			trip_q <= LSD_TRIP_RST;
		end
		else
		begin
			if (wr_ctrl) ctrl_q <= bus_wdata[LSD_CTRL_W-1:0];
			if (wr_tq_lim) tq_lim_q <= clamp(bus_wdata, LSD_LIM_MIN, LSD_LIM_MAX);
			if (wr_tq_dwell) tq_dwell_q <= clamp(bus_wdata, LSD_TIME_MIN, LSD_TIME_MAX);
			if (wr_settle) settle_q <= clamp(bus_wdata, LSD_TIME_MIN, LSD_TIME_MAX);
			if (wr_fuel_lim) fuel_lim_q <= clamp(bus_wdata, LSD_LIM_MIN, LSD_LIM_MAX);
			if (wr_fuel_dwell) fuel_dwell_q <= clamp(bus_wdata, LSD_TIME_MIN, LSD_TIME_MAX);
			if (wr_trip) trip_q <= clamp(bus_wdata, LSD_TRIP_RST, LSD_PCT_MAX);
		end
	end

	// differences, either direction counts
	wire [LSD_PCT_W-1:0] tq_abs = absdiff(own_torque, comp_torque);
	wire [LSD_PCT_W-1:0] fuel_abs = absdiff(own_fuel, comp_fuel);

	// supervision terms
	wire tick = pre_q == LSD_PRE_W'(TICK_CYCLES - 1);
	wire both_closed = ct.clutch_engaged & sync_q[8];
	wire settled = both_closed && LSD_DW'(settle_cnt_q) >= settle_q;
	wire tq_run = settled & !fuel_share_q && LSD_DW'(tq_abs) > tq_lim_q;
	wire fuel_run = settled & fuel_share_q && LSD_DW'(fuel_abs) > fuel_lim_q;
	wire tq_fire = tq_run && LSD_DW'(tq_cnt_q) >= tq_dwell_q;
	wire fuel_fire = fuel_run && LSD_DW'(fuel_cnt_q) >= fuel_dwell_q;
	wire is_slave = ctrl_q[LSD_C_SLAVE];
	wire arst = ct.alarm_reset;

	// alarm reset clears latches, but a new event in the same cycle wins
	wire fuel_share_d = tq_fire | (fuel_share_q & !arst);
	wire minor_d = (tq_fire & ctrl_q[LSD_C_MINOR_TQ])
		| (fuel_fire & ctrl_q[LSD_C_MINOR_FUEL]) | (minor_q & !arst);
	wire major_d = (tq_fire & ctrl_q[LSD_C_MAJOR_TQ]) | (major_q & !arst);
	wire declutch_d = (fuel_fire & is_slave) | (declutch_q & !arst);

	// clutch command: opening on an unloaded de-clutch takes priority
	wire want_open = !ct.clutch_request | ct.declutch_request | declutch_q;
	wire unloaded = LSD_DW'(engine_load) <= trip_q;
	wire want_close = ct.clutch_engaged | (ct.clutch_request & clutch_permissive_ok);
	wire clutch_d = (want_open & unloaded) ? 1'b0 : (want_close ? 1'b1 : clutch_q);

	// timebase wraps each tick; settle and dwell counters saturate
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			pre_q <= '0;
			settle_cnt_q <= '0;
			tq_cnt_q <= '0;
			fuel_cnt_q <= '0;
		end
		else if (ce)
		begin
			pre_q <= tick ? '0 : pre_q + 1'b1;
			if (!both_closed) settle_cnt_q <= '0;
			else if (tick && !settled) settle_cnt_q <= settle_cnt_q + 1'b1;
			if (!tq_run) tq_cnt_q <= '0;
			else if (tick && !tq_fire) tq_cnt_q <= tq_cnt_q + 1'b1;
			if (!fuel_run) fuel_cnt_q <= '0;
			else if (tick && !fuel_fire) fuel_cnt_q <= fuel_cnt_q + 1'b1;
		end
	end

	// mode, alarm latches and relays
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			fuel_share_q <= 1'b0;
			minor_q <= 1'b0;
			major_q <= 1'b0;
			declutch_q <= 1'b0;
			clutch_q <= 1'b0;
			relay1_q <= 1'b0;
			relay2_q <= 1'b0;
			prog_q <= 1'b1;
			tq_diff_q <= '0;
			fuel_diff_q <= '0;
		end
		else if (ce)
		begin
			fuel_share_q <= fuel_share_d;
			minor_q <= minor_d;
			major_q <= major_d;
			declutch_q <= declutch_d;
			clutch_q <= clutch_d;
			relay1_q <= minor_d ^ ctrl_q[LSD_C_MINOR_INV];
			relay2_q <= major_d ^ ctrl_q[LSD_C_MAJOR_INV];
			prog_q <= !ct.pclink_selected;
			tq_diff_q <= tq_abs;
			fuel_diff_q <= fuel_abs;
		end
	end

	// read mux; unmapped addresses read zero
	assign st = '{spare: 2'b00, settled: settled, clutch_cmd: clutch_q,
		slave_declutch: declutch_q, major_alarm: major_q, minor_alarm: minor_q,
		fuel_share: fuel_share_q};
	assign rd_d = (bus_addr == LSD_A_CTRL) ? LSD_DW'(ctrl_q) :
		(bus_addr == LSD_A_TQ_LIM) ? tq_lim_q :
		(bus_addr == LSD_A_TQ_DWELL) ? tq_dwell_q :
		(bus_addr == LSD_A_SETTLE) ? settle_q :
		(bus_addr == LSD_A_FUEL_LIM) ? fuel_lim_q :
		(bus_addr == LSD_A_FUEL_DWELL) ? fuel_dwell_q :
		(bus_addr == LSD_A_TRIP) ? trip_q :
		(bus_addr == LSD_A_STATUS) ? {ct, st} :
		(bus_addr == LSD_A_TQ_DIFF) ? LSD_DW'(tq_diff_q) :
		(bus_addr == LSD_A_FUEL_DIFF) ? LSD_DW'(fuel_diff_q) : '0;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			rdata_q <= '0;
		else if (ce)
			rdata_q <= bus_rd ? rd_d : '0;
	end

	assign bus_rdata = rdata_q;
	assign contact_flags = ct;
	assign programmer_enable = prog_q;
	assign fuel_share = fuel_share_q;
	assign minor_alarm = minor_q;
	assign major_alarm = major_q;
	assign relay_minor = relay1_q;
	assign relay_major = relay2_q;
	assign slave_declutch = declutch_q;
	assign clutch_cmd = clutch_q;
	assign torque_difference_readout = tq_diff_q;
	assign fuel_difference_readout = fuel_diff_q;

	// checks; ce low freezes state so most properties start from ce
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_tq_limit_range: assert property (tq_lim_q >= LSD_LIM_MIN && tq_lim_q <= LSD_LIM_MAX)
		else $error("torque limit out of range");
	a_dwell_range: assert property (tq_dwell_q >= LSD_TIME_MIN && tq_dwell_q <= LSD_TIME_MAX)
		else $error("torque dwell out of range");
	a_fall_to_fuel: assert property (ce && tq_fire |=> fuel_share_q)
		else $error("no switch to fuel sharing");
	a_major_on_fall: assert property (ce && tq_fire && ctrl_q[LSD_C_MAJOR_TQ] |=> major_q)
		else $error("major alarm not raised");
	a_settle_gates: assert property ($rose(fuel_share_q) |-> $past(settled))
		else $error("switch to fuel sharing before settle");
	a_tq_readout: assert property (ce |=> tq_diff_q == $past(tq_abs))
		else $error("torque readout stale");
	a_fuel_idle: assert property (ce && !fuel_share_q |=> fuel_cnt_q == '0)
		else $error("fuel timer ran in torque sharing");
	a_slave_declutch: assert property (ce && fuel_fire && is_slave |=> declutch_q
		&& (minor_q || !$past(ctrl_q[LSD_C_MINOR_FUEL])))
		else $error("slave de-clutch missing");
	a_prog_port: assert property (ce |=> prog_q != $past(ct.pclink_selected))
		else $error("programmer port sense wrong");
	a_minor_relay: assert property (ce |=> relay1_q ==
		(minor_q ^ $past(ctrl_q[LSD_C_MINOR_INV])))
		else $error("minor relay sense wrong");
	a_major_relay: assert property (ce |=> relay2_q ==
		(major_q ^ $past(ctrl_q[LSD_C_MAJOR_INV])))
		else $error("major relay sense wrong");
	a_clutch_open: assert property (ce && want_open && unloaded |=> !clutch_q)
		else $error("clutch did not open");
	a_dwell_restart: assert property (ce && !both_closed |=>
		tq_cnt_q == '0 && fuel_cnt_q == '0)
		else $error("dwell timer kept running");
	a_settle_range: assert property (settle_q >= LSD_TIME_MIN && settle_q <= LSD_TIME_MAX)
		else $error("settle time out of range");
	a_fuel_lim_range: assert property (fuel_lim_q >= LSD_LIM_MIN
		&& fuel_lim_q <= LSD_LIM_MAX)
		else $error("fuel limit out of range");
	a_fuel_dwell_range: assert property (fuel_dwell_q >= LSD_TIME_MIN
		&& fuel_dwell_q <= LSD_TIME_MAX)
		else $error("fuel dwell out of range");
	a_fuel_minor: assert property (ce && fuel_fire && ctrl_q[LSD_C_MINOR_FUEL] |=> minor_q)
		else $error("minor alarm not raised on fuel excess");
	a_master_keeps: assert property (ce && !is_slave && !declutch_q |=> !declutch_q)
		else $error("master unit commanded de-clutch");
	a_clutch_close: assert property (ce && want_close && !(want_open && unloaded)
		|=> clutch_q)
		else $error("clutch did not close");
	a_fuel_readout: assert property (ce |=> fuel_diff_q == $past(fuel_abs))
		else $error("fuel readout stale");

	c_fall_back: cover property (ce && tq_fire ##1 fuel_share_q);
	c_declutch: cover property (ce && fuel_fire && is_slave);
	c_alarm_clear: cover property (minor_q ##1 !minor_q);
	c_relay_inverted: cover property (ctrl_q[LSD_C_MINOR_INV] && relay1_q);
	c_clutch_close: cover property (ce && !clutch_q ##1 clutch_q);
endmodule
`default_nettype wire

// *** test_load_share_deviation_supervisor.sv ***
// self-checking bench for the load share deviation supervisor
// assumes lsd_companion plays the far engine and a tick shortened to four clocks
`timescale 1ns/100ps
`default_nettype none
module test_load_share_deviation_supervisor
	import lsd_pkg::*;
;
	localparam int TICK = 4;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic clutch_permissive_ok = 1'b0;
	logic clutch_set = 1'b0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [LSD_AW-1:0] bus_addr = 8'h00;
	logic [LSD_DW-1:0] bus_wdata = 16'h0000;
	logic [LSD_DW-1:0] bus_rdata;
	lsd_contacts_type contact_pins = 8'h00;
	lsd_contacts_type contact_flags;
	logic [LSD_PCT_W-1:0] own_torque = 11'h000;
	logic [LSD_PCT_W-1:0] own_fuel = 11'h000;
	logic [LSD_PCT_W-1:0] engine_load = 11'h100;
	logic [LSD_PCT_W-1:0] torque_set = 11'h000;
	logic [LSD_PCT_W-1:0] fuel_set = 11'h000;
	logic [LSD_PCT_W-1:0] comp_torque, comp_fuel, tq_diff, fuel_diff;
	logic comp_clutch_pin, programmer_enable, fuel_share, minor_alarm, major_alarm;
	logic relay_minor, relay_major, slave_declutch, clutch_cmd;
	// outputs the bounded wait can watch, by index
	localparam int W_SHARE = 0;
	localparam int W_RELAY = 1;
	localparam int W_DECL = 2;
	localparam int W_CLUTCH = 3;
	logic [3:0] obs;
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;
	// clock and hang guard; a hang still ends in the closing report
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			conclude();
		end
	end
	lsd_companion i_lsd_companion (.sys_clk(sys_clk), .torque_set(torque_set),
		.fuel_set(fuel_set), .clutch_set(clutch_set), .comp_torque(comp_torque),
		.comp_fuel(comp_fuel), .comp_clutch_pin(comp_clutch_pin));
	lsd_supervisor #(.TICK_CYCLES(TICK)) i_lsd_supervisor (.sys_clk(sys_clk), .reset(reset),
		.ce(ce), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .contact_pins(contact_pins), .comp_clutch_pin(comp_clutch_pin),
		.own_torque(own_torque), .comp_torque(comp_torque), .own_fuel(own_fuel),
		.comp_fuel(comp_fuel), .engine_load(engine_load),
		.clutch_permissive_ok(clutch_permissive_ok), .contact_flags(contact_flags),
		.programmer_enable(programmer_enable), .fuel_share(fuel_share),
		.minor_alarm(minor_alarm), .major_alarm(major_alarm), .relay_minor(relay_minor),
		.relay_major(relay_major), .slave_declutch(slave_declutch), .clutch_cmd(clutch_cmd),
		.torque_difference_readout(tq_diff), .fuel_difference_readout(fuel_diff));
	assign obs = {clutch_cmd, slave_declutch, relay_minor, fuel_share};
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask
	// bounded wait, sampled at the falling edge where registers have settled
	task automatic await(input int b, input logic v);
		int n;
		n = 0;
		@(negedge sys_clk);
		while (obs[b] !== v && n < 400)
		begin
			@(negedge sys_clk);
			n++;
		end
		chk1(obs[b], v);
	endtask
	// bus cycles end with an idle cycle so a strobe is never driven twice in one step
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1 chk(bus_rdata, e);
		@(posedge sys_clk);
	endtask
	task automatic clamp(input logic [7:0] a, input logic [15:0] lo, input logic [15:0] hi);
		wr(a, 16'h0000);
		rdchk(a, lo);
		wr(a, 16'hFFFF);
		rdchk(a, hi);
	endtask
	task automatic t_reset();
		@(negedge sys_clk);
		chk1(programmer_enable, 1'b1);
		chk1(fuel_share, 1'b0);
		chk1(relay_minor, 1'b0);
		@(posedge sys_clk);
		rdchk(LSD_A_TQ_LIM, LSD_LIM_RST);
		rdchk(LSD_A_SETTLE, LSD_TIME_RST);
		rdchk(8'h3C, 16'h0000);
		wr(LSD_A_TQ_DIFF, 16'hFFFF);
		rdchk(LSD_A_TQ_DIFF, 16'h0000);
		clamp(LSD_A_TQ_LIM, LSD_LIM_MIN, LSD_LIM_MAX);
		clamp(LSD_A_TQ_DWELL, LSD_TIME_MIN, LSD_TIME_MAX);
		clamp(LSD_A_SETTLE, LSD_TIME_MIN, LSD_TIME_MAX);
		clamp(LSD_A_FUEL_LIM, LSD_LIM_MIN, LSD_LIM_MAX);
		clamp(LSD_A_FUEL_DWELL, LSD_TIME_MIN, LSD_TIME_MAX);
		clamp(LSD_A_TRIP, LSD_TRIP_RST, LSD_PCT_MAX);
		wr(LSD_A_TRIP, LSD_TRIP_RST);
		$display("test reset and registers done");
	endtask
	// one contact closed at a time; two sync flops plus the derived output
	task automatic t_contacts();
		for (int i = 0; i < 8; i++)
		begin
			contact_pins <= 8'h01 << i;
			repeat (3) @(posedge sys_clk);
			@(negedge sys_clk);
			chk({8'h00, contact_flags}, 16'h0001 << i);
			chk1(programmer_enable, i != 7);
			@(posedge sys_clk);
		end
		contact_pins <= 8'h00;
		repeat (4) @(posedge sys_clk);
		$display("test contacts done");
	endtask
	task automatic t_fallback();
		wr(LSD_A_CTRL, 16'h0027);
		rdchk(LSD_A_CTRL, 16'h0027);
		wr(LSD_A_TQ_LIM, 16'h000A);
		wr(LSD_A_TQ_DWELL, 16'h0002);
		wr(LSD_A_SETTLE, 16'h0002);
		wr(LSD_A_FUEL_LIM, 16'h000A);
		wr(LSD_A_FUEL_DWELL, 16'h0002);
		own_torque <= 11'h12C;
		torque_set <= 11'h1F4;
		own_fuel <= 11'h064;
		fuel_set <= 11'h064;
		clutch_set <= 1'b1;
		contact_pins <= 8'h18;
		repeat (6) @(posedge sys_clk);
		#1 chk1(fuel_share, 1'b0);
		await(W_SHARE, 1'b1);
		chk({5'h00, tq_diff}, 16'h00C8);
		chk1(minor_alarm, 1'b1);
		chk1(major_alarm, 1'b1);
		chk1(relay_minor, 1'b1);
		chk1(relay_major, 1'b1);
		chk1(clutch_cmd, 1'b1);
		@(posedge sys_clk);
		// contacts 0x18, settled, clutch closed, major, minor, fuel sharing
		rdchk(LSD_A_STATUS, 16'h1837);
		own_fuel <= 11'h190;
		await(W_DECL, 1'b1);
		chk({5'h00, fuel_diff}, 16'h012C);
		@(posedge sys_clk);
		torque_set <= 11'h12C;
		own_fuel <= 11'h064;
		contact_pins <= 8'h58;
		await(W_SHARE, 1'b0);
		chk1(minor_alarm, 1'b0);
		chk1(major_alarm, 1'b0);
		chk1(slave_declutch, 1'b0);
		@(posedge sys_clk);
		contact_pins <= 8'h18;
		wr(LSD_A_CTRL, 16'h0018);
		await(W_RELAY, 1'b1);
		chk1(relay_major, 1'b1);
		@(posedge sys_clk);
		torque_set <= 11'h1F4;
		await(W_SHARE, 1'b1);
		chk1(minor_alarm, 1'b0);
		chk1(relay_major, 1'b1);
		// master role: fuel excess must neither de-clutch nor raise a disabled alarm
		@(posedge sys_clk);
		own_fuel <= 11'h190;
		repeat (40) @(posedge sys_clk);
		@(negedge sys_clk);
		chk1(slave_declutch, 1'b0);
		chk1(minor_alarm, 1'b0);
		chk1(relay_minor, 1'b1);
		@(posedge sys_clk);
		own_fuel <= 11'h064;
		$display("test fallback done");
	endtask
	// load above the trip point keeps the clutch in; unloading lets it open
	task automatic t_clutch();
		contact_pins <= 8'h08;
		repeat (6) @(posedge sys_clk);
		#1 chk1(clutch_cmd, 1'b1);
		@(posedge sys_clk);
		engine_load <= 11'h000;
		await(W_CLUTCH, 1'b0);
		// requested with all permissives met closes it again without engagement
		@(posedge sys_clk);
		contact_pins <= 8'h10;
		clutch_permissive_ok <= 1'b1;
		await(W_CLUTCH, 1'b1);
		$display("test clutch done");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_contacts();
		t_fallback();
		t_clutch();
		conclude();
	end
endmodule
`default_nettype wire
